//--- design/ppc_pkg.sv
// Package: constants for the parallel port controller
package ppc_pkg;
  localparam logic [7:0] PPC_ADDR_CMD      = 8'he8;
  localparam logic [7:0] PPC_ADDR_PORTA    = 8'he9;
  localparam logic [7:0] PPC_ADDR_PORTB    = 8'hea;
  localparam logic [7:0] PPC_ADDR_PORTC    = 8'heb;
  localparam logic [7:0] PPC_CMD_RESET     = 8'h00;
  localparam logic [7:0] PPC_PORTA_RESET   = 8'h00;
  localparam logic [7:0] PPC_CMD_INIT      = 8'h41;
  localparam int         PPC_CMD_PA_DIR    = 0;
  localparam int         PPC_CMD_PB_DIR    = 1;
  localparam int         PPC_CMD_PC_LO     = 2;
  localparam int         PPC_CMD_PC_HI     = 3;
  localparam int         PPC_CMD_PA_IEN    = 4;
  localparam int         PPC_CMD_PB_IEN    = 5;
  localparam int         PPC_CMD_TMR_LO    = 6;
  localparam int         PPC_CMD_TMR_HI    = 7;
  localparam int         PPC_STAT_TMR      = 6;
  localparam int         PPC_PA_SERRST     = 4;
  localparam int         PPC_PA_IRQRST     = 5;
  localparam int         PPC_PA_CRQ        = 6;
  localparam int         PPC_PA_DPR        = 7;
  localparam logic [1:0] PPC_TMR_STOP      = 2'b01;
endpackage

//--- design/ppc_sync.sv
// Two-flop synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none
module ppc_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          s1_q[g] <= 1'b0;
          q_o[g]  <= 1'b0;
        end else begin
          s1_q[g] <= d_i[g];
          q_o[g]  <= s1_q[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

//--- design/ppc_top.sv
// Parallel port controller: command/status and ports A, B, C
// Operation
// - One 8-bit output, 8-bit and 6-bit inputs
// - Command holds port modes, interrupt enables, timer
// - Command write at E8 takes effect immediately
// - Status: port bits 0-3 (bits 4-5 zero), timer bit 6
// - Read E8 gives status, write gives command
// - Reset puts ports in default configuration
// - Command 41 hex: A out, B/C in, stop timer
// - Port A drives digits, resets, call lines
// - Port B carries ring and carrier inputs
// - Port C carries calling status, flag, power
// - Write E9 loads port A; read returns it
// - Reads at EA, EB return ports B, C
`timescale 1ns/1ps
`default_nettype none
module ppc_top
  import ppc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] io_addr_i,
  input  wire logic [7:0] io_wdata_i,
  input  wire logic       io_wr_i,
  input  wire logic       io_rd_i,
  output logic      [7:0] io_rdata_o,
  output logic            io_rvalid_o,
  output logic      [3:0] dial_digit_o,
  output logic            serial_ctrl_reset_o,
  output logic            irq_flop_reset_o,
  output logic            call_request_o,
  output logic            digit_present_o,
  output logic            porta_oe_o,
  input  wire logic [3:0] ring_ind_i,
  input  wire logic [3:0] carrier_det_i,
  input  wire logic       next_digit_request_i,
  input  wire logic       call_origination_status_i,
  input  wire logic       line_occupied_i,
  input  wire logic       abandon_call_retry_i,
  input  wire logic       flag_interrupt_in_i,
  input  wire logic       power_status_in_i,
  output logic      [1:0] timer_cmd_o,
  output logic            porta_irq_en_o,
  output logic            portb_irq_en_o
);

  logic [7:0]  cmd_q;
  logic [7:0]  porta_q;
  logic [5:0]  stat_q;
  logic        tmr_stat_q;
  logic [7:0]  pb_s;
  logic [5:0]  pc_s;
  logic [7:0]  rdata_d;

  // Pins from outside pass two flops first
  ppc_sync #(.W(8)) u_sync_b (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({carrier_det_i, ring_ind_i}),
    .q_o   (pb_s)
  );
  ppc_sync #(.W(6)) u_sync_c (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({power_status_in_i, flag_interrupt_in_i,
             abandon_call_retry_i, line_occupied_i,
             call_origination_status_i, next_digit_request_i}),
    .q_o   (pc_s)
  );

  // Command register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_q <= PPC_CMD_RESET;
    end else if (io_wr_i && io_addr_i == PPC_ADDR_CMD) begin
      cmd_q <= io_wdata_i;
    end
  end

  // Port A output latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      porta_q <= PPC_PORTA_RESET;
    end else if (io_wr_i && io_addr_i == PPC_ADDR_PORTA) begin
      porta_q <= io_wdata_i;
    end
  end

  // Timer status: set when a stop command is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_stat_q <= 1'b0;
    end else if (io_wr_i && io_addr_i == PPC_ADDR_CMD &&
                 io_wdata_i[PPC_CMD_TMR_HI:PPC_CMD_TMR_LO]
                   == PPC_TMR_STOP) begin
      tmr_stat_q <= 1'b1;
    end else if (io_rd_i && io_addr_i == PPC_ADDR_CMD) begin
      tmr_stat_q <= 1'b0;
    end
  end

  // Port status bits track port B/C activity
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= 6'h00;
    end else begin
      stat_q <= {2'b00, |pc_s[5:4], |pc_s[3:0], |pb_s[7:4], |pb_s[3:0]};
    end
  end

  always_comb begin
    rdata_d = 8'h00;
    unique case (io_addr_i)
      PPC_ADDR_CMD:   rdata_d = {1'b0, tmr_stat_q, stat_q};
      PPC_ADDR_PORTA: rdata_d = porta_q;
      PPC_ADDR_PORTB: rdata_d = pb_s;
      PPC_ADDR_PORTC: rdata_d = {2'b00, pc_s};
      default:        rdata_d = 8'h00;
    endcase
  end

  // Read data registered, one cycle after strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_rdata_o  <= 8'h00;
      io_rvalid_o <= 1'b0;
    end else begin
      io_rvalid_o <= io_rd_i;
      if (io_rd_i) begin
        io_rdata_o <= rdata_d;
      end
    end
  end

  assign dial_digit_o        = porta_q[3:0];
  assign serial_ctrl_reset_o = porta_q[PPC_PA_SERRST];
  assign irq_flop_reset_o    = porta_q[PPC_PA_IRQRST];
  assign call_request_o      = porta_q[PPC_PA_CRQ];
  assign digit_present_o     = porta_q[PPC_PA_DPR];
  assign porta_oe_o          = cmd_q[PPC_CMD_PA_DIR];
  assign porta_irq_en_o      = cmd_q[PPC_CMD_PA_IEN];
  assign portb_irq_en_o      = cmd_q[PPC_CMD_PB_IEN];
  assign timer_cmd_o         = cmd_q[PPC_CMD_TMR_HI:PPC_CMD_TMR_LO];

  AST_CMD_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
    io_wr_i && io_addr_i == PPC_ADDR_CMD |=> cmd_q == $past(io_wdata_i))
    else $error("command write not taken");

  AST_INIT_CMD: assert property (@(posedge clk_i) disable iff (rst_i)
    io_wr_i && io_addr_i == PPC_ADDR_CMD && io_wdata_i == PPC_CMD_INIT
    |=> porta_oe_o && timer_cmd_o == PPC_TMR_STOP)
    else $error("init command misapplied");

  AST_PORTA_WR: assert property (@(posedge clk_i) disable iff (rst_i)
    io_wr_i && io_addr_i == PPC_ADDR_PORTA
    |=> {digit_present_o, call_request_o, irq_flop_reset_o,
         serial_ctrl_reset_o, dial_digit_o} == $past(io_wdata_i))
    else $error("port A write not on pins");

  AST_PORTA_RD: assert property (@(posedge clk_i) disable iff (rst_i)
    io_rd_i && io_addr_i == PPC_ADDR_PORTA && !io_wr_i
    |=> io_rvalid_o && io_rdata_o == porta_q)
    else $error("port A readback wrong");

  AST_PB_RD: assert property (@(posedge clk_i) disable iff (rst_i)
    io_rd_i && io_addr_i == PPC_ADDR_PORTB |=> io_rdata_o == $past(pb_s))
    else $error("port B read wrong");

  AST_PC_RD: assert property (@(posedge clk_i) disable iff (rst_i)
    io_rd_i && io_addr_i == PPC_ADDR_PORTC
    |=> io_rdata_o == {2'b00, $past(pc_s)})
    else $error("port C read wrong");

  AST_STAT_RD: assert property (@(posedge clk_i) disable iff (rst_i)
    io_rd_i && io_addr_i == PPC_ADDR_CMD |=> io_rdata_o[7] == 1'b0)
    else $error("status bit 7 not zero");

  AST_RESET: assert property (@(posedge clk_i)
    rst_i |=> cmd_q == PPC_CMD_RESET && porta_q == PPC_PORTA_RESET)
    else $error("reset state wrong");

  // Decoded bus strobes, watched by the checks below
  logic        wr_cmd;
  logic        wr_pa;
  logic        rd_cmd;
  logic        rd_map;
  assign wr_cmd = io_wr_i && io_addr_i == PPC_ADDR_CMD;
  assign wr_pa  = io_wr_i && io_addr_i == PPC_ADDR_PORTA;
  assign rd_cmd = io_rd_i && io_addr_i == PPC_ADDR_CMD;
  assign rd_map = io_addr_i == PPC_ADDR_CMD || io_addr_i == PPC_ADDR_PORTA ||
                  io_addr_i == PPC_ADDR_PORTB || io_addr_i == PPC_ADDR_PORTC;

  // Bus steps that the checks start from
  sequence s_cmd_wr;
    wr_cmd;
  endsequence
  sequence s_pa_wr;
    wr_pa;
  endsequence
  sequence s_stop_wr;
    wr_cmd && io_wdata_i[PPC_CMD_TMR_HI:PPC_CMD_TMR_LO] == PPC_TMR_STOP;
  endsequence
  sequence s_stat_rd;
    rd_cmd && !io_wr_i;
  endsequence
  sequence s_any_rd;
    io_rd_i;
  endsequence
  sequence s_unmap_rd;
    io_rd_i && !rd_map;
  endsequence
  sequence s_idle_bus;
    !io_rd_i && !io_wr_i;
  endsequence

  AST_RVALID_HI: assert property (@(posedge clk_i) disable iff (rst_i)
    s_any_rd
    |=> io_rvalid_o)
    else $error("read not answered");

  AST_RVALID_LO: assert property (@(posedge clk_i) disable iff (rst_i)
    !io_rd_i
    |=> !io_rvalid_o)
    else $error("read valid without read");

  AST_UNMAP_RD: assert property (@(posedge clk_i) disable iff (rst_i)
    s_unmap_rd
    |=> io_rdata_o == 8'h00)
    else $error("unmapped read not zero");

  AST_RDATA_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    !io_rd_i
    |=> $stable(io_rdata_o))
    else $error("read data moved without read");

  AST_TMR_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    s_stop_wr
    |=> tmr_stat_q)
    else $error("timer status not set by stop");

  AST_TMR_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
    s_stat_rd
    |=> !tmr_stat_q)
    else $error("timer status not cleared by read");

  AST_STAT_TMR: assert property (@(posedge clk_i) disable iff (rst_i)
    s_stat_rd
    |=> io_rdata_o[PPC_STAT_TMR] == $past(tmr_stat_q))
    else $error("status timer bit wrong");

  AST_STAT_PORTS: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> stat_q[3:0] == {|$past(pc_s[5:4]), |$past(pc_s[3:0]),
                             |$past(pb_s[7:4]), |$past(pb_s[3:0])})
    else $error("port status bits wrong");

  AST_CMD_FIELDS: assert property (@(posedge clk_i) disable iff (rst_i)
    s_cmd_wr
    |=> {timer_cmd_o, portb_irq_en_o, porta_irq_en_o} == $past(io_wdata_i[7:4])
        && porta_oe_o == $past(io_wdata_i[0]))
    else $error("command fields not on outputs");

  AST_CMD_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_cmd
    |=> $stable(cmd_q))
    else $error("command changed without write");

  AST_PA_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_pa
    |=> $stable(porta_q))
    else $error("port A changed without write");

  AST_IDLE_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
    s_idle_bus
    |=> $stable(dial_digit_o) && $stable(timer_cmd_o))
    else $error("outputs moved on idle bus");

  AST_PC_RD_TOP: assert property (@(posedge clk_i) disable iff (rst_i)
    io_rd_i && io_addr_i == PPC_ADDR_PORTC
    |=> io_rdata_o[7:6] == 2'b00)
    else $error("port C upper bits not zero");

  AST_RST_OUT: assert property (@(posedge clk_i)
    rst_i
    |=> !io_rvalid_o && io_rdata_o == 8'h00 && !tmr_stat_q)
    else $error("read side not reset");

endmodule
`default_nettype wire

//--- tb/ppc_partner.sv
// Calling unit and modem status lines seen by the port controller
`timescale 1ns/1ps
`default_nettype none
module ppc_partner (
  input  wire logic        call_request_i,
  input  wire logic [13:0] pins_i,
  output logic      [7:0]  pb_o,
  output logic      [5:0]  pc_o
);
  // Ring in low nibble, carrier in high nibble
  assign pb_o = pins_i[7:0];
  // Digit request, status, occupied, abandon, flag, power
  assign pc_o = pins_i[13:8];
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the parallel port controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ppc_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        io_wr_i = 1'b0;
  logic        io_rd_i = 1'b0;
  logic [7:0]  io_addr_i = 8'h00;
  logic [7:0]  io_wdata_i = 8'h00;
  logic [13:0] pins = 14'h0000;
  logic [7:0]  io_rdata_o, pb, m_pa, m_cmd;
  logic [5:0]  pc;
  logic [3:0]  dd;
  logic [1:0]  tmr;
  logic        rv, sr, ir, cr, dp, oe, ae, be, t6;
  logic [31:0] s = 32'h834a1191;
  int          errors = 0;
  int          check_count = 0;
  always #20 clk_i = ~clk_i;
  ppc_top i_ppc_top (.clk_i(clk_i), .rst_i(rst_i), .io_addr_i(io_addr_i),
    .io_wdata_i(io_wdata_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
    .io_rdata_o(io_rdata_o), .io_rvalid_o(rv), .dial_digit_o(dd),
    .serial_ctrl_reset_o(sr), .irq_flop_reset_o(ir), .call_request_o(cr),
    .digit_present_o(dp), .porta_oe_o(oe), .ring_ind_i(pb[3:0]),
    .carrier_det_i(pb[7:4]), .next_digit_request_i(pc[0]),
    .call_origination_status_i(pc[1]), .line_occupied_i(pc[2]),
    .abandon_call_retry_i(pc[3]), .flag_interrupt_in_i(pc[4]),
    .power_status_in_i(pc[5]), .timer_cmd_o(tmr), .porta_irq_en_o(ae),
    .portb_irq_en_o(be));
  ppc_partner i_ppc_partner (.call_request_i(cr), .pins_i(pins),
    .pb_o(pb), .pc_o(pc));
  task automatic final_report;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = 1'b1;
    @(negedge clk_i);
    io_wr_i = 1'b0;
    if (a == PPC_ADDR_PORTA) m_pa = d;
    if (a == PPC_ADDR_CMD) m_cmd = d;
    if (a == PPC_ADDR_CMD && d[7:6] == PPC_TMR_STOP) t6 = 1'b1;
    chk({dp, cr, ir, sr, dd}, m_pa);
    chk({tmr, be, ae, 3'b000, oe}, m_cmd & 8'hf1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    io_addr_i = a;
    io_rd_i = 1'b1;
    @(negedge clk_i);
    io_rd_i = 1'b0;
    chk({7'h00, rv}, 8'h01);
    chk(io_rdata_o, exp);
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [7:0] stat();
    return {1'b0, t6, 2'b00, |pins[13:12], |pins[11:8], |pins[7:4],
            |pins[3:0]};
  endfunction
  initial begin
    #200000;
    errors++;
    final_report();
  end
  initial begin
    m_pa = 8'h00;
    m_cmd = 8'h00;
    t6 = 1'b0;
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    rd(PPC_ADDR_PORTA, 8'h00);
    wr(PPC_ADDR_CMD, PPC_CMD_INIT);
    rd(PPC_ADDR_CMD, stat());
    t6 = 1'b0;
    rd(PPC_ADDR_CMD, stat());
    wr(PPC_ADDR_PORTA, 8'hc0);
    for (int i = 0; i < 24; i++) begin
      s = lfsr(s);
      pins = s[13:0];
      wr(PPC_ADDR_PORTA, s[21:14]);
      wr(PPC_ADDR_CMD, s[31:24]);
      rd(PPC_ADDR_PORTB, pins[7:0]);
      rd(PPC_ADDR_PORTC, {2'b00, pins[13:8]});
      rd(PPC_ADDR_PORTA, m_pa);
      rd(PPC_ADDR_CMD, stat());
      t6 = 1'b0;
    end
    rd(8'hf0, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
